/* icsw_core.sv */
`timescale 1ns/10ps
`default_nettype none
// Contract
// - config 110 gives 1 MHz, 000 64 MHz
// - post divider 1:1 up to 1:512
// - constant 500 kHz and 31.25 kHz mid clocks
// - mid clocks never selectable as system clock
// - low-frequency clock feeds timer, watchdog, monitor
// - converter clock 600 kHz, manual or auto enable
// - tune resets zero, six-bit two's complement
// - tune touches only high-frequency oscillator
// - tune drifts, no completion status
// - ready bit per oscillator, no PLL enable
// - frequency write clears hf and mid ready
// - mid clocks freeze while frequency change pending
// - switch enable gates request writes
// - old clock runs until new source ready
// - ready and interrupt flag set together
// - switch interrupt never wakes from sleep
// - hold clear switches as soon as ready
// - hold set keeps old clock; abandon by copy
// - switch on next cycle regardless of doze
// - current fields update at switch, ready cleared
// - PLL input change suspends, lock failure flagged
// - sleep pauses pending switch unless in lock or swap, resumes on wake without rerequest
// - source code decode with reserved codes
// - divider codes 0 to 9, rest reserved
// - reserved source write is ignored
module icsw_core
  import icsw_pkg::*;
#(
  parameter int LOCK_CYCLES = (PLL_LOCK_US * 1000) / CLK_PERIOD_NS
)
(
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic [2:0] RESET_SOURCE_CONFIG,
  input wire logic CLOCK_SWITCH_ENABLE,
  input wire logic REQ_WR,
  input wire icsw_sel_s REQ_SEL,
  input wire logic SWITCH_HOLD,
  input wire logic SWITCH_INT_ENABLE,
  input wire logic SWITCH_FLAG_CLR,
  input wire logic SLEEP,
  input wire logic HF_FREQ_WR,
  input wire logic [3:0] HF_FREQ_SELECT,
  input wire logic TUNE_WR,
  input wire icsw_tune_t FREQ_TUNE_IN,
  input wire logic [4:0] OSC_MANUAL_ENABLE,
  input wire logic CONV_SELECTS_RC,
  input wire logic [5:0] OSC_READY_RAW,
  input wire logic [4:0] OSC_CLK_RAW,
  output logic SYS_CLK,
  output logic MID_CLK_500K,
  output logic MID_CLK_31K,
  output logic LF_CLK_OUT,
  output logic CONV_RC_CLK,
  output logic [4:0] OSC_ENABLE,
  output logic [7:0] OSC_READY_STATUS,
  output var icsw_sel_s CURRENT_SEL,
  output var icsw_sel_s REQUESTED_SEL,
  output logic NEW_SOURCE_READY,
  output logic OSC_SWITCH_DONE,
  output logic SWITCH_INT_FLAG,
  output logic SWITCH_IRQ,
  output logic [3:0] HF_FREQ_FIELD,
  output var icsw_tune_t FREQ_TUNE,
  output logic CORE_SUSPEND,
  output logic FAILSAFE_TRIGGER
);
  localparam int LCW = $clog2(LOCK_CYCLES + 1);
  localparam int CHW = $clog2(CONV_HALF + 1);

  if (LOCK_CYCLES < 1)
  begin : g_chk
    $error("icsw_core: lock budget below one cycle");
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic valid_src(input logic [2:0] s);
    return (s == SRC_EXT) || (s == SRC_HF) || (s == SRC_LF) ||
           (s == SRC_SOSC) || (s == SRC_PLL);
  endfunction

  // mid clocks have no code here, so they can never be picked
  function automatic logic src_pick(input logic [2:0] s,
                                    input logic [4:0] v);
    logic r;
    r = 1'b0;
    case (s)
      SRC_EXT: r = v[CK_EXT];
      SRC_HF: r = v[CK_HF];
      SRC_LF: r = v[CK_LF];
      SRC_SOSC: r = v[CK_SOSC];
      SRC_PLL: r = v[CK_PLL];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic icsw_sel_s rst_sel(input logic [2:0] c);
    icsw_sel_s r;
    r.src = c;
    r.div = DIV_BY1;
    if (c == RST_HF_1M)
      r.div = DIV_BY4;
    else if (!valid_src(c))
      r.src = SRC_HF;
    return r;
  endfunction

  // hf rising edges per half period of the 500 kHz clock
  function automatic logic [6:0] mid_half(input logic [3:0] f);
    logic [6:0] h;
    h = 7'h01;
    case (f)
      4'h0: h = 7'h01;
      4'h1: h = 7'h02;
      4'h2: h = 7'h04;
      4'h3: h = 7'h08;
      4'h4: h = 7'h0c;
      4'h5: h = 7'h10;
      4'h6: h = 7'h20;
      4'h7: h = 7'h30;
      default: h = 7'h40;
    endcase
    return h;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [10:0] sync_out;
  logic [5:0] rdy;
  logic [4:0] clk_lvl;
  logic [4:0] rdy_vec;
  icsw_state_e state_q;
  icsw_sel_s cur_q;
  icsw_sel_s req_q;
  icsw_sel_s a_sel;
  icsw_sel_s b_sel;
  logic sel_q;
  logic lvl_a;
  logic lvl_b;
  logic old_lvl;
  logic new_lvl;
  logic pending;
  logic new_ready;
  logic pll_change;
  logic commit;
  logic lock_fail;
  logic nsr_set;
  logic [LCW-1:0] lock_cnt_q;
  logic [3:0] frq_q;
  logic settle_q;
  logic hf_prev_q;
  logic hfr_prev_q;
  logic [6:0] mid_cnt_q;
  logic [3:0] mid_sub_q;
  logic [CHW-1:0] conv_cnt_q;
  logic conv_en;

  icsw_sync #(.W(11)) u_sync (
    .clk(MCLK),
    .rst(SRST),
    .d({OSC_CLK_RAW, OSC_READY_RAW}),
    .q(sync_out)
  );
  assign rdy = sync_out[5:0];
  assign clk_lvl = sync_out[10:6];
  // the PLL source is ready once its reference is; lock is checked later
  assign rdy_vec = {rdy[RR_EXT], rdy[RR_SOSC], rdy[RR_LF], rdy[RR_HF],
                    rdy[RR_EXT]};

  ////////////////////////////////////////////////////////////////////////////
  // two dividers swap roles so the live one never changes phase at commit
  assign a_sel = sel_q ? req_q : cur_q;
  assign b_sel = sel_q ? cur_q : req_q;

  icsw_div u_div_a (
    .clk(MCLK),
    .rst(SRST),
    .lvl_in(src_pick(a_sel.src, clk_lvl)),
    .div(a_sel.div),
    .lvl_out(lvl_a)
  );

  icsw_div u_div_b (
    .clk(MCLK),
    .rst(SRST),
    .lvl_in(src_pick(b_sel.src, clk_lvl)),
    .div(b_sel.div),
    .lvl_out(lvl_b)
  );

  assign old_lvl = sel_q ? lvl_b : lvl_a;
  assign new_lvl = sel_q ? lvl_a : lvl_b;
  assign pending = (req_q != cur_q);
  assign new_ready = (req_q.src == cur_q.src) ||
                     src_pick(req_q.src, rdy_vec);
  assign pll_change = (req_q.src == SRC_PLL) != (cur_q.src == SRC_PLL);
  // the commit waits only on clock levels, never on the core
  assign commit = (state_q == S_SWAP) && !old_lvl && !new_lvl &&
                  !SYS_CLK;
  assign lock_fail = (state_q == S_LOCK) && !rdy[RR_PLL] &&
                     (lock_cnt_q == '0);
  assign nsr_set = (state_q == S_WAIT) && pending && !SLEEP && new_ready;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      state_q <= S_IDLE;
    else
    begin
      unique case (state_q)
        S_IDLE:
          if (pending && !SLEEP)
            state_q <= S_WAIT;
        S_WAIT:
          if (SLEEP || !pending)
            state_q <= S_IDLE;
          else if (new_ready)
            state_q <= S_HOLD;
        S_HOLD:
          if (SLEEP || !pending)
            state_q <= S_IDLE;
          else if (!SWITCH_HOLD)
            state_q <= pll_change ? S_LOCK : S_SWAP;
        S_LOCK:
          if (rdy[RR_PLL])
            state_q <= S_SWAP;
          else if (lock_cnt_q == '0)
            state_q <= S_IDLE;
        S_SWAP:
          if (commit)
            state_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (SRST || state_q != S_LOCK)
      lock_cnt_q <= LCW'(LOCK_CYCLES - 1);
    else if (lock_cnt_q != '0)
      lock_cnt_q <= lock_cnt_q - LCW'(1);
  end

  // strap is taken while the synchronous reset is held
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      req_q <= rst_sel(RESET_SOURCE_CONFIG);
    else if (lock_fail)
      req_q <= cur_q;
    else if (REQ_WR && CLOCK_SWITCH_ENABLE && valid_src(REQ_SEL.src) &&
             REQ_SEL.div <= DIV_MAX)
      req_q <= REQ_SEL;
  end

  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      cur_q <= rst_sel(RESET_SOURCE_CONFIG);
      sel_q <= 1'b0;
    end
    else if (commit)
    begin
      cur_q <= req_q;
      sel_q <= ~sel_q;
    end
  end

  // the output can only fall during a swap, then sits low until commit
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      SYS_CLK <= 1'b0;
    else if (state_q == S_SWAP)
      SYS_CLK <= SYS_CLK & old_lvl;
    else
      SYS_CLK <= old_lvl;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      NEW_SOURCE_READY <= 1'b0;
      OSC_SWITCH_DONE <= 1'b1;
      SWITCH_INT_FLAG <= 1'b0;
      SWITCH_IRQ <= 1'b0;
      CORE_SUSPEND <= 1'b0;
      FAILSAFE_TRIGGER <= 1'b0;
    end
    else
    begin
      if (nsr_set)
        NEW_SOURCE_READY <= 1'b1;
      else if (commit || lock_fail ||
               (state_q == S_HOLD && (SLEEP || !pending)))
        NEW_SOURCE_READY <= 1'b0;
      if (commit)
        OSC_SWITCH_DONE <= 1'b1;
      else if (pending)
        OSC_SWITCH_DONE <= 1'b0;
      // a new event beats a clear in the same cycle
      if (nsr_set)
        SWITCH_INT_FLAG <= 1'b1;
      else if (SWITCH_FLAG_CLR)
        SWITCH_INT_FLAG <= 1'b0;
      SWITCH_IRQ <= SWITCH_INT_FLAG && SWITCH_INT_ENABLE && !SLEEP;
      CORE_SUSPEND <= (state_q == S_LOCK);
      FAILSAFE_TRIGGER <= lock_fail;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frequency select and ready tracking
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      frq_q <= (RESET_SOURCE_CONFIG == RST_HF_64M) ? FRQ_64M : FRQ_4M;
      settle_q <= 1'b0;
      hfr_prev_q <= 1'b0;
    end
    else
    begin
      hfr_prev_q <= rdy[RR_HF];
      if (HF_FREQ_WR && HF_FREQ_SELECT <= FRQ_MAX)
      begin
        frq_q <= HF_FREQ_SELECT;
        settle_q <= 1'b1;
      end
      else if (rdy[RR_HF] && !hfr_prev_q)
        settle_q <= 1'b0;
    end
  end

  // tune only goes to the hf oscillator; drift is analog and unreported
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      FREQ_TUNE <= icsw_tune_t'(TUNE_RST);
    else if (TUNE_WR)
      FREQ_TUNE <= FREQ_TUNE_IN;
  end

  ////////////////////////////////////////////////////////////////////////////
  // mid clocks count hf edges; the count adapts to the hf setting
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      hf_prev_q <= 1'b0;
      mid_cnt_q <= 7'h00;
      mid_sub_q <= 4'h0;
      MID_CLK_500K <= 1'b0;
      MID_CLK_31K <= 1'b0;
    end
    else
    begin
      hf_prev_q <= clk_lvl[CK_HF];
      if (!settle_q && clk_lvl[CK_HF] && !hf_prev_q)
      begin
        if (mid_cnt_q >= mid_half(frq_q) - 7'h01)
        begin
          mid_cnt_q <= 7'h00;
          MID_CLK_500K <= ~MID_CLK_500K;
          mid_sub_q <= mid_sub_q + 4'h1;
          if (mid_sub_q == 4'(MID_SLOW_MUL - 1))
            MID_CLK_31K <= ~MID_CLK_31K;
        end
        else
          mid_cnt_q <= mid_cnt_q + 7'h01;
      end
    end
  end

  assign conv_en = OSC_MANUAL_ENABLE[EN_CONV] || CONV_SELECTS_RC;

  always_ff @(posedge MCLK)
  begin
    if (SRST || !conv_en)
    begin
      conv_cnt_q <= '0;
      CONV_RC_CLK <= 1'b0;
    end
    else if (conv_cnt_q == CHW'(CONV_HALF - 1))
    begin
      conv_cnt_q <= '0;
      CONV_RC_CLK <= ~CONV_RC_CLK;
    end
    else
      conv_cnt_q <= conv_cnt_q + CHW'(1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // enables and status; there is deliberately no PLL enable
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      OSC_ENABLE <= 5'h00;
      OSC_READY_STATUS <= 8'h00;
      LF_CLK_OUT <= 1'b0;
      HF_FREQ_FIELD <= 4'h0;
      CURRENT_SEL <= '0;
      REQUESTED_SEL <= '0;
    end
    else
    begin
      OSC_ENABLE[EN_CONV] <= conv_en;
      OSC_ENABLE[EN_SOSC] <= OSC_MANUAL_ENABLE[EN_SOSC] ||
        cur_q.src == SRC_SOSC || req_q.src == SRC_SOSC;
      OSC_ENABLE[EN_LF] <= OSC_MANUAL_ENABLE[EN_LF] ||
        cur_q.src == SRC_LF || req_q.src == SRC_LF;
      OSC_ENABLE[EN_HF] <= OSC_MANUAL_ENABLE[EN_HF] ||
        cur_q.src == SRC_HF || req_q.src == SRC_HF;
      OSC_ENABLE[EN_EXT] <= OSC_MANUAL_ENABLE[EN_EXT] ||
        cur_q.src == SRC_EXT || req_q.src == SRC_EXT ||
        cur_q.src == SRC_PLL || req_q.src == SRC_PLL;
      OSC_READY_STATUS[ST_EXT] <= rdy[RR_EXT];
      OSC_READY_STATUS[ST_HF] <= rdy[RR_HF] && !settle_q;
      OSC_READY_STATUS[ST_MID] <= rdy[RR_HF] && !settle_q;
      OSC_READY_STATUS[ST_LF] <= rdy[RR_LF];
      OSC_READY_STATUS[ST_SOSC] <= rdy[RR_SOSC];
      OSC_READY_STATUS[ST_CONV] <= rdy[RR_CONV];
      OSC_READY_STATUS[1] <= 1'b0;
      OSC_READY_STATUS[ST_PLL] <= rdy[RR_PLL];
      LF_CLK_OUT <= clk_lvl[CK_LF];
      HF_FREQ_FIELD <= frq_q;
      // shown in the same cycle as the done bit, not one behind it
      CURRENT_SEL <= commit ? req_q : cur_q;
      REQUESTED_SEL <= req_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_src_reserved: assert property (@(posedge MCLK) disable iff (SRST)
    REQ_WR && !valid_src(REQ_SEL.src) && state_q != S_LOCK
    |=> req_q == $past(req_q))
    else $error("reserved source code was stored");
  a_wr_locked: assert property (@(posedge MCLK) disable iff (SRST)
    !CLOCK_SWITCH_ENABLE && state_q != S_LOCK |=> $stable(req_q))
    else $error("request changed with switching disabled");
  a_flag_pair: assert property (@(posedge MCLK) disable iff (SRST)
    $rose(NEW_SOURCE_READY) |-> SWITCH_INT_FLAG)
    else $error("ready set without the interrupt flag");
  a_hold_keeps: assert property (@(posedge MCLK) disable iff (SRST)
    state_q == S_HOLD && SWITCH_HOLD |=> $stable(cur_q) ##1 $stable(cur_q))
    else $error("clock changed while held");
  a_commit_low: assert property (@(posedge MCLK) disable iff (SRST)
    cur_q != $past(cur_q) |-> !$past(old_lvl) && !$past(new_lvl)
      && !$past(SYS_CLK))
    else $error("hand over while a clock was high");
  a_switch_done: assert property (@(posedge MCLK) disable iff (SRST)
    commit |=> !NEW_SOURCE_READY && OSC_SWITCH_DONE && CURRENT_SEL == cur_q)
    else $error("switch did not update status");
  a_irq_sleep: assert property (@(posedge MCLK) disable iff (SRST)
    SLEEP |=> !SWITCH_IRQ)
    else $error("switch interrupt raised during sleep");
  a_lock_susp: assert property (@(posedge MCLK) disable iff (SRST)
    state_q == S_LOCK |=> CORE_SUSPEND)
    else $error("no suspend during relock");
  a_same_ready: assert property (@(posedge MCLK) disable iff (SRST)
    state_q == S_WAIT && pending && !SLEEP && req_q.src == cur_q.src
    |=> NEW_SOURCE_READY)
    else $error("divider-only change not ready at once");
  a_hf_clear: assert property (@(posedge MCLK) disable iff (SRST)
    HF_FREQ_WR && HF_FREQ_SELECT <= FRQ_MAX
    |=> ##1 !OSC_READY_STATUS[ST_HF] && !OSC_READY_STATUS[ST_MID])
    else $error("ready bits not cleared by frequency write");
  a_no_hold_go: assert property (@(posedge MCLK) disable iff (SRST)
    state_q == S_HOLD && !SWITCH_HOLD && pending && !SLEEP && !pll_change
    |=> state_q == S_SWAP)
    else $error("switch did not proceed with hold clear");
endmodule
`default_nettype wire

/* icsw_div.sv */
`timescale 1ns/10ps
`default_nettype none
module icsw_div
  import icsw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic lvl_in,
  input wire logic [3:0] div,
  output logic lvl_out
);
  logic in_q;
  logic [8:0] cnt_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      in_q <= 1'b0;
      cnt_q <= 9'h000;
    end
    else
    begin
      in_q <= lvl_in;
      if (lvl_in && !in_q)
        cnt_q <= cnt_q + 9'h001;
    end
  end

  // bit k of a rising-edge counter divides by 2^(k+1)
  always_comb
  begin
    if (div == DIV_BY1 || div > DIV_MAX)
      lvl_out = lvl_in;
    else
      lvl_out = cnt_q[div - 4'h1];
  end
endmodule
`default_nettype wire

/* icsw_osc_model.sv */
`timescale 1ns/10ps
`default_nettype none
module icsw_osc_model
  import icsw_pkg::*;
(
  input wire logic clk,
  input wire logic [3:0] freq_field,
  input wire logic [4:0] osc_en,
  input wire logic lock_fail,
  output logic [5:0] ready_raw,
  output logic [4:0] clk_raw
);
  // ext, hf, lf, sosc, pll half periods; all slower than clk/4
  localparam int HALF [5] = '{5, 4, 13, 11, 3};
  int cnt [5] = '{default: 0};
  int settle = 0;
  logic [3:0] frq_last = 4'h0;
  logic [4:0] lvl = 5'h00;
  //////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    for (int k = 0; k < 5; k++)
    begin
      cnt[k] <= (cnt[k] == HALF[k] - 1) ? 0 : cnt[k] + 1;
      if (cnt[k] == HALF[k] - 1)
        lvl[k] <= ~lvl[k];
    end
    frq_last <= freq_field;
    // new rate: not ready while the oscillator drifts over
    if (freq_field != frq_last)
      settle <= 40;
    else if (settle > 0)
      settle <= settle - 1;
  end
  assign clk_raw = lvl;
  // lock withheld only while lock_fail is high
  assign ready_raw = {1'h1, settle == 0, 2'h3, osc_en[EN_CONV], ~lock_fail};
endmodule
`default_nettype wire

/* icsw_pkg.sv */
`default_nettype none
package icsw_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MCLK_HZ = 100_000_000;
  // plain default budget for a relock, not a documented figure
  localparam int PLL_LOCK_US = 2000;
  localparam int CONV_RC_HZ = 600_000;
  // half period of the converter clock, rounded down
  localparam int CONV_HALF = MCLK_HZ / (2 * CONV_RC_HZ);
  localparam int MID_SLOW_MUL = 16;
  ////////////////////////////////////////////////////////////////////////////
  // source codes
  localparam logic [2:0] SRC_EXT = 3'h7;
  localparam logic [2:0] SRC_HF = 3'h6;
  localparam logic [2:0] SRC_LF = 3'h5;
  localparam logic [2:0] SRC_SOSC = 3'h4;
  localparam logic [2:0] SRC_PLL = 3'h2;
  localparam logic [2:0] RST_HF_1M = 3'h6;
  localparam logic [2:0] RST_HF_64M = 3'h0;
  localparam logic [3:0] DIV_BY1 = 4'h0;
  localparam logic [3:0] DIV_BY4 = 4'h2;
  localparam logic [3:0] DIV_MAX = 4'h9;
  localparam logic [3:0] FRQ_4M = 4'h2;
  localparam logic [3:0] FRQ_64M = 4'h8;
  localparam logic [3:0] FRQ_MAX = 4'h8;
  localparam logic [5:0] TUNE_RST = 6'h00;
  ////////////////////////////////////////////////////////////////////////////
  // bit positions
  localparam int ST_EXT = 7;
  localparam int ST_HF = 6;
  localparam int ST_MID = 5;
  localparam int ST_LF = 4;
  localparam int ST_SOSC = 3;
  localparam int ST_CONV = 2;
  localparam int ST_PLL = 0;
  localparam int RR_PLL = 0;
  localparam int RR_CONV = 1;
  localparam int RR_SOSC = 2;
  localparam int RR_LF = 3;
  localparam int RR_HF = 4;
  localparam int RR_EXT = 5;
  localparam int CK_EXT = 0;
  localparam int CK_HF = 1;
  localparam int CK_LF = 2;
  localparam int CK_SOSC = 3;
  localparam int CK_PLL = 4;
  localparam int EN_CONV = 0;
  localparam int EN_SOSC = 1;
  localparam int EN_LF = 2;
  localparam int EN_HF = 3;
  localparam int EN_EXT = 4;
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [2:0] src;
    logic [3:0] div;
  } icsw_sel_s;
  typedef logic signed [5:0] icsw_tune_t;
  typedef enum {S_IDLE, S_WAIT, S_HOLD, S_LOCK, S_SWAP} icsw_state_e;
endpackage
`default_nettype wire

/* icsw_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module icsw_sync
  import icsw_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  if (W < 1)
  begin : g_chk
    $error("icsw_sync: width below one");
  end

  // meta_q feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import icsw_pkg::*;
;
  logic mclk = 1'h0, srst = 1'h1, cse = 1'h1, req_wr = 1'h0, hold = 1'h0;
  logic ie = 1'h1, fclr = 1'h0, sleep = 1'h0, fwr = 1'h0, twr = 1'h0;
  logic csrc = 1'h0, lock_fail = 1'h0, b;
  logic [2:0] strap = RST_HF_1M;
  logic [3:0] fsel = FRQ_4M;
  logic [4:0] men = 5'h00;
  icsw_sel_s rsel = '0;
  icsw_tune_t tin = '0;
  logic sys_clk, m500, m31, lf_o, conv_o, nsr, done, flag, irq, susp, fs;
  logic [3:0] ffield;
  logic [4:0] osc_en, clk_raw;
  logic [5:0] rdy_raw;
  logic [7:0] stat;
  icsw_sel_s cur, rq;
  icsw_tune_t tune;
  int mismatches = 0, cmp_count = 0, i;
  wire logic [4:0] ev = {stat[ST_HF], fs, susp, nsr, done};
  //////////////////////////////////////////////////////////////////////////
  icsw_core #(.LOCK_CYCLES(20)) DUT (
    .MCLK(mclk), .SRST(srst), .RESET_SOURCE_CONFIG(strap),
    .CLOCK_SWITCH_ENABLE(cse), .REQ_WR(req_wr), .REQ_SEL(rsel),
    .SWITCH_HOLD(hold), .SWITCH_INT_ENABLE(ie), .SWITCH_FLAG_CLR(fclr),
    .SLEEP(sleep), .HF_FREQ_WR(fwr), .HF_FREQ_SELECT(fsel),
    .TUNE_WR(twr), .FREQ_TUNE_IN(tin), .OSC_MANUAL_ENABLE(men),
    .CONV_SELECTS_RC(csrc), .OSC_READY_RAW(rdy_raw),
    .OSC_CLK_RAW(clk_raw), .SYS_CLK(sys_clk), .MID_CLK_500K(m500),
    .MID_CLK_31K(m31), .LF_CLK_OUT(lf_o), .CONV_RC_CLK(conv_o),
    .OSC_ENABLE(osc_en), .OSC_READY_STATUS(stat), .CURRENT_SEL(cur),
    .REQUESTED_SEL(rq), .NEW_SOURCE_READY(nsr), .OSC_SWITCH_DONE(done),
    .SWITCH_INT_FLAG(flag), .SWITCH_IRQ(irq), .HF_FREQ_FIELD(ffield),
    .FREQ_TUNE(tune), .CORE_SUSPEND(susp), .FAILSAFE_TRIGGER(fs)
  );
  icsw_osc_model osc (.clk(mclk), .freq_field(ffield), .osc_en(osc_en),
    .lock_fail(lock_fail), .ready_raw(rdy_raw), .clk_raw(clk_raw));
  always #(CLK_PERIOD_NS / 2) mclk = ~mclk;
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ck(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // returns on the edge that takes the strobe
  task automatic req(input icsw_sel_s s);
    @(posedge mclk);
    req_wr <= 1'h1;
    rsel <= s;
    @(posedge mclk);
    req_wr <= 1'h0;
  endtask
  // sampled after the edge so one-cycle pulses are not missed
  task automatic wait_ev(input int w);
    for (i = 0; i < 400 && ev[w] !== 1'h1; i++)
      ck(1);
    chk(ev[w], 1'h1);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset(input logic [2:0] s, input icsw_sel_s e,
    input logic [3:0] f);
    @(posedge mclk);
    srst <= 1'h1;
    strap <= s;
    repeat (5) @(posedge mclk);
    srst <= 1'h0;
    ck(2);
    chk(cur, e);
    chk(rq, e);
    chk(ffield, f);
    chk({2'h0, tune}, {2'h0, TUNE_RST});
    chk(done, 1'h1);
  endtask
  task automatic t_div();
    req({SRC_HF, DIV_BY1});
    ck(3);
    chk(rq, {SRC_HF, DIV_BY1});
    chk(done, 1'h0);
    chk(cur, {SRC_HF, DIV_BY4});
    wait_ev(0);
    chk(cur, {SRC_HF, DIV_BY1});
    chk(nsr, 1'h0);
    chk(flag, 1'h1);
  endtask
  task automatic t_refuse();
    @(posedge mclk);
    cse <= 1'h0;
    req({SRC_LF, DIV_BY1});
    cse <= 1'h1;
    ck(3);
    chk(rq, {SRC_HF, DIV_BY1});
    req({3'h0, DIV_BY1});
    req({3'h3, DIV_BY1});
    ck(3);
    chk(rq, {SRC_HF, DIV_BY1});
    req({SRC_LF, 4'hA});
    ck(3);
    chk(rq, {SRC_HF, DIV_BY1});
  endtask
  task automatic t_hold();
    @(posedge mclk);
    fclr <= 1'h1;
    hold <= 1'h1;
    @(posedge mclk);
    fclr <= 1'h0;
    req({SRC_LF, DIV_BY1});
    chk(flag, 1'h0);
    wait_ev(1);
    chk(flag, 1'h1);
    ck(20);
    chk(irq, 1'h1);
    chk(cur, {SRC_HF, DIV_BY1});
    // abandon by asking for what already runs
    req({SRC_HF, DIV_BY1});
    ck(4);
    chk(nsr, 1'h0);
    chk(flag, 1'h1);
    req({SRC_LF, DIV_BY1});
    wait_ev(1);
    @(posedge mclk);
    hold <= 1'h0;
    wait_ev(0);
    chk(cur, {SRC_LF, DIV_BY1});
  endtask
  task automatic t_sleep();
    @(posedge mclk);
    sleep <= 1'h1;
    req({SRC_HF, DIV_BY1});
    ck(30);
    chk(irq, 1'h0);
    chk(nsr, 1'h0);
    chk(cur, {SRC_LF, DIV_BY1});
    @(posedge mclk);
    fclr <= 1'h1;
    @(posedge mclk);
    fclr <= 1'h0;
    sleep <= 1'h0;
    wait_ev(0);
    chk(cur, {SRC_HF, DIV_BY1});
    chk(flag, 1'h1);
  endtask
  task automatic t_pll();
    @(posedge mclk);
    lock_fail <= 1'h1;
    req({SRC_PLL, DIV_BY1});
    wait_ev(2);
    chk(cur, {SRC_HF, DIV_BY1});
    wait_ev(3);
    ck(3);
    chk(rq, {SRC_HF, DIV_BY1});
    @(posedge mclk);
    lock_fail <= 1'h0;
    req({SRC_PLL, DIV_BY1});
    ck(3);
    wait_ev(0);
    chk(cur, {SRC_PLL, DIV_BY1});
  endtask
  task automatic t_clk();
    int n_sys = 0, n_m5 = 0, n_m3 = 0, n_lf = 0;
    logic p_sys, p_m5, p_m3, p_lf;
    ck(4);
    chk(osc_en, 5'h10);
    {p_sys, p_m5, p_m3, p_lf} = {sys_clk, m500, m31, lf_o};
    // windows are whole periods of each model clock, so counts are exact
    for (int k = 0; k < 1536; k++)
    begin
      ck(1);
      if (k < 768 && sys_clk && !p_sys)
        n_sys++;
      if (m500 != p_m5)
        n_m5++;
      if (m31 != p_m3)
        n_m3++;
      if (k < 1040 && lf_o && !p_lf)
        n_lf++;
      {p_sys, p_m5, p_m3, p_lf} = {sys_clk, m500, m31, lf_o};
    end
    chk(8'(n_sys), 8'h80);
    chk(8'(n_m5), 8'h30);
    chk(8'(n_m3), 8'h03);
    chk(8'(n_lf), 8'h28);
  endtask
  task automatic t_freq();
    @(posedge mclk);
    fwr <= 1'h1;
    fsel <= FRQ_64M;
    @(posedge mclk);
    fwr <= 1'h0;
    ck(4);
    chk(ffield, FRQ_64M);
    chk(stat[ST_HF], 1'h0);
    chk(stat[ST_MID], 1'h0);
    b = m500;
    // longer than one live half period, shorter than the settle time
    ck(34);
    chk(m500, b);
    wait_ev(4);
    chk(stat[ST_MID], 1'h1);
  endtask
  task automatic t_tune(input icsw_tune_t v);
    @(posedge mclk);
    twr <= 1'h1;
    tin <= v;
    @(posedge mclk);
    twr <= 1'h0;
    ck(1);
    chk({2'h0, tune}, {2'h0, v});
  endtask
  task automatic t_conv(input logic [4:0] m, input logic c, input logic e);
    @(posedge mclk);
    men <= m;
    csrc <= c;
    ck(8);
    chk(osc_en[EN_CONV], e);
    chk(stat[ST_CONV], e);
    chk(stat[1], 1'h0);
    ck(CONV_HALF - 3);
    chk(conv_o, e);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #(20_000 * CLK_PERIOD_NS);
    mismatches++;
    final_report();
  end
  initial
  begin
    t_reset(RST_HF_1M, {SRC_HF, DIV_BY4}, FRQ_4M);
    t_div();
    t_refuse();
    t_hold();
    t_sleep();
    t_pll();
    t_clk();
    t_freq();
    t_tune(6'sh1f);
    t_tune(6'sh20);
    t_conv(5'h01, 1'h0, 1'h1);
    t_conv(5'h00, 1'h0, 1'h0);
    t_conv(5'h00, 1'h1, 1'h1);
    t_reset(RST_HF_64M, {SRC_HF, DIV_BY1}, FRQ_64M);
    final_report();
  end
endmodule
`default_nettype wire
